// *** bench/bridge_control_and_error_log_tb_top.sv ***
// Purpose: Self-checking bench for the bridge control registers and error log.
// Assumes: Shortened rom and wake counts.
// Notes: Inputs change on the falling edge.
`timescale 1ns/1ps
module bridge_control_and_error_log_tb_top;
	import bridge_ctl_pkg::*;
	logic ref_clk_i = '0, reset_n_i = '0, pci_reset_active_i = '0, rom_clock_line_i = '0;
	logic id_strap_pin_i = '0, hold_off_strap_i = '0, arbiter_strap_i = '0, abort_valid_i = '0;
	logic abort_is_target_i = '0, power_wake_i = '0, in_d3hot_i = '0, wake_support_flag_i = '0;
	logic local_interrupt_pin_n_i = '1, bridge_chip_select_n_i = '1, slave_image_select_i = '0;
	logic slv_burst_i = '0, slv_posted_i = '0, pw_error_i = '0;
	logic [31:0] local_data_i = '0, slv_addr_i = '0, pw_addr_i = '0, pw_data_i = '0;
	logic [7:0] rom_rdata_i = 8'h5A;
	logic [3:0] local_parity_i = '0, pw_code_i = '0;
	logic [1:0] pw_size_i = '0;
	logic reg_req_i, reg_from_pci_i, reg_write_i, reg_ack_o, reg_retry_o, port_parked_pci_o;
	logic abort_bus_error_o, abort_normal_o, full_burst_only_o, single_prefetch_o;
	logic image1_prefetch_select_o, parity_error_o, ordering_enforce_o, local_reset_out_n_o;
	logic wake_request_o, pci_hold_off_o, arbiter_enable_o, slv_valid_o, slv_image_o;
	logic slv_bus_error_o, slv_delayed_write_o, error_irq_o;
	logic [31:0] reg_wdata_i, reg_rdata_o, slv_pci_addr_o;
	logic [7:0] image1_prefetch_bytes_o;
	logic [3:0] local_parity_o;
	logic [2:0] reg_index_i;
	int n_fail = 0, n_compared = 0;
	typedef struct packed {logic [2:0] i; logic [31:0] d; logic [31:0] e;} row_t;
	row_t rows [5] = '{'{IDX_MISC_TWO, 32'h0006_FFFF, 32'h0006_FFFF},
		'{IDX_IMAGE0_XLAT, 32'h1234_5610, 32'h1234_0010},
		'{IDX_IMAGE1_XLAT, 32'hABCD_FFF0, 32'hABCD_0030},
		'{3'h7, 32'hFFFF_FFFF, 32'h0000_0000}, '{IDX_ERR_CS, 32'h0000_0001, 32'h0000_0001}};
	logic [31:0] amap [3] = '{32'h0002_0001, 32'h0002_0000, 32'h0000_0000};
	always #5 ref_clk_i = ~ref_clk_i;
	bridge_control_and_error_log #(.ACCESS_CYCLES(4), .BOOT_CYCLES(8), .WAKE_CYCLES(4))
		u_bridge_control_and_error_log (.*);
	bridge_host_model u_bridge_host_model (.ref_clk_i(ref_clk_i), .reg_ack_i(reg_ack_o),
		.reg_retry_i(reg_retry_o), .reg_rdata_i(reg_rdata_o), .reg_req_o(reg_req_i),
		.reg_from_pci_o(reg_from_pci_i), .reg_write_o(reg_write_i),
		.reg_index_o(reg_index_i), .reg_wdata_o(reg_wdata_i));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk_i);
	endtask
	task automatic acc(input logic p, w, input logic [2:0] i, input logic [31:0] d, e,
		input logic r);
		logic [31:0] q;
		logic a, t;
		u_bridge_host_model.access(p, w, i, d, q, a, t);
		chk({30'h0, a, t}, {30'h0, !r, r});
		if (!w && !r) chk(q, e);
	endtask
	task automatic results();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		#200000;
		n_fail++;
		results();
	end
	initial begin
		cyc(2);
		reset_n_i = 1'b1;
		cyc(1);
		chk({21'h0, port_parked_pci_o, ordering_enforce_o, local_reset_out_n_o,
			image1_prefetch_bytes_o}, 32'h0000_0704);
		acc(0, 0, IDX_MISC_TWO, 0, 32'h0000_0008, 0);
		foreach (rows[k]) begin
			acc(0, 1, rows[k].i, rows[k].d, 0, 0);
			acc(0, 0, rows[k].i, 0, rows[k].e, 0);
		end
		chk({19'h0, full_burst_only_o, single_prefetch_o, image1_prefetch_select_o,
			ordering_enforce_o, port_parked_pci_o, image1_prefetch_bytes_o},
			32'h0000_1CFC);
		{local_data_i, local_parity_i} = {32'h0000_0001, 4'hE};
		{in_d3hot_i, wake_support_flag_i, local_interrupt_pin_n_i} = 3'h6;
		cyc(2);
		chk({26'h0, wake_request_o, parity_error_o, local_parity_o}, 32'h0000_002E);
		$display("register rows done");
		{bridge_chip_select_n_i, slave_image_select_i, slv_addr_i, slv_burst_i} = {2'h1, 32'h1234, 1'b1};
		cyc(2);
		chk(slv_pci_addr_o, 32'hABCD_1234);
		chk({29'h0, slv_image_o, slv_bus_error_o, slv_valid_o}, 32'h0000_0007);
		{slv_burst_i, slv_posted_i} = 2'h1;
		cyc(1);
		chk({30'h0, slv_delayed_write_o, slv_bus_error_o}, 32'h0000_0002);
		{slave_image_select_i, slv_addr_i, slv_posted_i} = {1'b0, 32'h5678_9ABC, 1'b0};
		cyc(1);
		chk({slv_image_o, slv_pci_addr_o[30:0]}, 32'h1234_9ABC);
		bridge_chip_select_n_i = 1'b1;
		{pw_addr_i, pw_data_i, pw_code_i, pw_size_i, pw_error_i} = {32'hA5A0, 32'h1357_9BDF, 7'h5D};
		cyc(1);
		pw_error_i = 1'b0;
		acc(0, 0, IDX_ERR_CS, 0, 32'h0000_2B03, 0);
		acc(0, 0, IDX_ERR_ADDR, 0, 32'h0000_A5A0, 0);
		acc(0, 0, IDX_ERR_DATA, 0, 32'h1357_9BDF, 0);
		chk({31'h0, error_irq_o}, 32'h0000_0001);
		acc(0, 1, IDX_ERR_CS, 32'h0000_0002, 0, 0);
		acc(0, 0, IDX_ERR_CS, 0, 32'h0000_0000, 0);
		acc(0, 0, IDX_ERR_ADDR, 0, 32'h0000_0000, 0);
		$display("decode and log done");
		power_wake_i = 1'b1;
		cyc(1);
		power_wake_i = 1'b0;
		cyc(1);
		chk({31'h0, local_reset_out_n_o}, 32'h0000_0000);
		cyc(5);
		chk({31'h0, local_reset_out_n_o}, 32'h0000_0001);
		for (int k = 0; k < 3; k++) begin
			acc(0, 1, IDX_MISC_TWO, amap[k], 0, 0);
			{abort_is_target_i, abort_valid_i} = {k < 2, 1'b1};
			cyc(1);
			chk({30'h0, abort_bus_error_o, abort_normal_o}, {30'h0, k != 1, k == 1});
			abort_valid_i = 1'b0;
		end
		$display("power and abort done");
		pci_reset_active_i = 1'b1;
		cyc(2);
		pci_reset_active_i = 1'b0;
		cyc(2);
		acc(0, 1, IDX_ROM_ACCESS, 32'h0001_03FF, 0, 0);
		acc(1, 0, IDX_ROM_ACCESS, 0, 32'h0000_0000, 0);
		acc(0, 1, IDX_MISC_TWO, 32'h0000_1000, 0, 0);
		acc(1, 1, IDX_ROM_ACCESS, 32'h0000_0300, 0, 0);
		acc(0, 0, IDX_ROM_ACCESS, 0, 32'h8000_0000, 0);
		cyc(1);
		acc(0, 0, IDX_ROM_ACCESS, 0, 32'h0000_035A, 0);
		{hold_off_strap_i, arbiter_strap_i, id_strap_pin_i, pci_reset_active_i} = 4'hF;
		cyc(2);
		pci_reset_active_i = 1'b0;
		cyc(1);
		chk({30'h0, pci_hold_off_o, arbiter_enable_o}, 32'h0000_0003);
		acc(0, 0, IDX_ROM_ACCESS, 0, 32'h8000_0000, 0);
		acc(1, 0, IDX_MISC_TWO, 0, 0, 1);
		acc(0, 1, IDX_MISC_TWO, 0, 0, 0);
		acc(1, 0, IDX_MISC_TWO, 0, 32'h0008_0000, 0);
		$display("rom and straps done");
		results();
	end
endmodule

// *** bench/bridge_host_model.sv ***
// Purpose: Register port master standing for the local processor and the PCI host.
// Assumes: The answer comes one cycle after the request edge.
// Notes: Write data is inverted once the request is released.
`timescale 1ns/1ps
module bridge_host_model (
	input wire logic ref_clk_i, // Clock.
	input wire logic reg_ack_i, // Normal end.
	input wire logic reg_retry_i, // Retry.
	input wire logic [31:0] reg_rdata_i, // Read data.
	output logic reg_req_o, // Request pulse.
	output logic reg_from_pci_o, // Request from PCI.
	output logic reg_write_o, // Write.
	output logic [2:0] reg_index_o, // Word index.
	output logic [31:0] reg_wdata_o // Write data.
);
	initial begin
		{reg_req_o, reg_from_pci_o, reg_write_o, reg_index_o, reg_wdata_o} = '0;
	end
	task automatic access(input logic p, w, input logic [2:0] i, input logic [31:0] d,
		output logic [31:0] q, output logic a, t);
		@(negedge ref_clk_i);
		{reg_req_o, reg_from_pci_o, reg_write_o, reg_index_o, reg_wdata_o} = {1'b1, p, w, i, d};
		@(negedge ref_clk_i);
		{q, a, t} = {reg_rdata_i, reg_ack_i, reg_retry_i};
		reg_req_o = 1'b0;
		reg_wdata_o = ~d;
	endtask
endmodule

// *** pkg/bridge_ctl_pkg.sv ***
// Purpose: Shared constants for the bridge control and error log block.
// Assumes: Register port carries a 3-bit word index and 32-bit data.
// Notes: Offsets are word indices on the register access port.
package bridge_ctl_pkg;
	// ------------------------------------------------------------
	// Register indices
	// ------------------------------------------------------------
	localparam logic [2:0] IDX_ROM_ACCESS = 3'h0;
	localparam logic [2:0] IDX_MISC_TWO = 3'h1;
	localparam logic [2:0] IDX_IMAGE0_XLAT = 3'h2;
	localparam logic [2:0] IDX_IMAGE1_XLAT = 3'h3;
	localparam logic [2:0] IDX_ERR_CS = 3'h4;
	localparam logic [2:0] IDX_ERR_ADDR = 3'h5;
	localparam logic [2:0] IDX_ERR_DATA = 3'h6;
	// ------------------------------------------------------------
	// Rom access register fields
	// ------------------------------------------------------------
	localparam int ROM_BUSY_BIT = 31;
	localparam int ROM_WRITE_BIT = 16;
	localparam int ROM_ADDR_LSB = 8;
	// ------------------------------------------------------------
	// Second miscellaneous control fields
	// ------------------------------------------------------------
	localparam int M_TA_MAP = 0;
	localparam int M_FULL_BURST = 1;
	localparam int M_SINGLE_PF = 2;
	localparam int M_PF_COUNT_LSB = 3;
	localparam int M_POSTED_IMPROVE = 9;
	localparam int M_PARKING = 10;
	localparam int M_PARITY_ODD = 11;
	localparam int M_LATE_ROM = 12;
	localparam int M_ORDER_BYPASS = 13;
	localparam int M_WAKE_RESET = 14;
	localparam int M_IRQ_WAKE = 15;
	localparam int M_HOLD_OFF = 16;
	localparam int M_ABORT_MAP_DIS = 17;
	localparam int M_IMG1_PF_SEL = 18;
	localparam int M_ARBITER_EN = 19;
	localparam logic [31:0] MISC_TWO_RESET = 32'h0000_0008;
	localparam logic [31:0] MISC_TWO_WMASK = 32'h0007_FFFF;
	// ------------------------------------------------------------
	// Translation register fields
	// ------------------------------------------------------------
	localparam int X_BS_LSB = 0;
	localparam int X_REMAP_EN = 4;
	localparam int X_IO_SPACE = 5;
	localparam int X_ADDR_LSB = 16;
	localparam logic [31:0] XLAT_WMASK = 32'hFFFF_003F;
	localparam logic [31:0] XLAT_RESET = 32'h0000_0000;
	localparam logic [31:0] BLOCK_BASE_MASK = 32'hFFFF_0000;
	// ------------------------------------------------------------
	// Error log control fields
	// ------------------------------------------------------------
	localparam int E_ENABLE = 0;
	localparam int E_LOGGED = 1;
	localparam int E_CODE_LSB = 8;
	localparam int E_SIZE_LSB = 12;
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int ROM_ACCESS_CYCLES = 64;
	localparam int ROM_BOOT_CYCLES = 512;
	localparam int WAKE_RESET_CYCLES = 16;
endpackage

// *** src/bridge_control_and_error_log.sv ***
// Purpose: Control and status registers of the bus bridge, with error log.
// Assumes: All inputs are synchronous to ref_clk_i.
// Notes: One register port is shared by the local bus and PCI sides.
// Functional notes
// (R1) Rom register works only while not busy
// (R2) Rom register writes always terminate normally; PCI writes are retried instead while the hold-off bit is set
// (R3) No rom at reset: register reads zero
// (R4) Late enable bit restores rom access
// (R5) Abort mapping picks bus error or normal
// (R6) Full burst bit forces four-beat bursts
// (R7) Single prefetch bit selects single cycles
// (R8) Image one prefetches four times count
// (R9) Parking bit keeps port on last bus
// (R10) Parity select: zero even, one odd
// (R11) Order bypass disables transaction ordering
// (R12) Wake from D3hot pulses local reset
// (R13) Interrupt pin in D3hot may request wake
// (R14) Hold-off strap retries all PCI accesses
// (R15) Arbiter strap enables internal arbiter
// (R16) Image select picks slave image
// (R17) Burst to I/O space gives bus error
// (R18) Image one posted I/O writes become delayed
// (R19) Remap replaces upper address lines
// (R20) Posted write error captured, flag set
// (R21) Flag cleared by one with enable zero
// (R22) Log fields read zero while flag clear; the error data register still returns log_data then
`timescale 1ns/1ps
module bridge_control_and_error_log #(
	parameter int ACCESS_CYCLES = bridge_ctl_pkg::ROM_ACCESS_CYCLES,
	parameter int BOOT_CYCLES = bridge_ctl_pkg::ROM_BOOT_CYCLES,
	parameter int WAKE_CYCLES = bridge_ctl_pkg::WAKE_RESET_CYCLES
) (
	input wire logic ref_clk_i, // Clock, 100 MHz.
	input wire logic reset_n_i, // Global reset, active low.
	input wire logic pci_reset_active_i, // PCI reset asserted, level.
	input wire logic rom_clock_line_i, // Rom clock line strap.
	input wire logic id_strap_pin_i, // Identification strap.
	input wire logic hold_off_strap_i, // Hold-off strap pin.
	input wire logic arbiter_strap_i, // Arbiter enable strap.
	input wire logic [7:0] rom_rdata_i, // Rom read data.
	input wire logic reg_req_i, // Register access request pulse.
	input wire logic reg_from_pci_i, // Request comes from PCI.
	input wire logic reg_write_i, // Request is a write.
	input wire logic [2:0] reg_index_i, // Register word index.
	input wire logic [31:0] reg_wdata_i, // Write data.
	input wire logic abort_valid_i, // PCI abort on delayed cycle.
	input wire logic abort_is_target_i, // Abort is target abort.
	input wire logic [31:0] local_data_i, // Local data for parity.
	input wire logic [3:0] local_parity_i, // Local parity received.
	input wire logic power_wake_i, // Host D3hot to D0 change pulse.
	input wire logic in_d3hot_i, // Power state is D3hot.
	input wire logic wake_support_flag_i, // Wake support enabled.
	input wire logic local_interrupt_pin_n_i, // Local interrupt pin, low.
	input wire logic bridge_chip_select_n_i, // Slave chip select, low.
	input wire logic slave_image_select_i, // Slave image select.
	input wire logic [31:0] slv_addr_i, // Local slave address.
	input wire logic slv_burst_i, // Local slave burst.
	input wire logic slv_posted_i, // Single posted write.
	input wire logic pw_error_i, // Posted write bus error pulse.
	input wire logic [31:0] pw_addr_i, // Failed write address.
	input wire logic [31:0] pw_data_i, // Failed write data.
	input wire logic [3:0] pw_code_i, // Failed transfer code.
	input wire logic [1:0] pw_size_i, // Failed transfer size.
	output logic reg_ack_o, // Normal termination pulse.
	output logic reg_retry_o, // Retry pulse.
	output logic [31:0] reg_rdata_o, // Read data.
	output logic port_parked_pci_o, // Register port on PCI side.
	output logic abort_bus_error_o, // Abort ends as bus error.
	output logic abort_normal_o, // Abort ends normally.
	output logic full_burst_only_o, // Four-beat bursts only.
	output logic single_prefetch_o, // Prefetch with single cycles.
	output logic [7:0] image1_prefetch_bytes_o, // Image 1 prefetch bytes.
	output logic image1_prefetch_select_o, // Image 1 prefetch select.
	output logic [3:0] local_parity_o, // Generated parity.
	output logic parity_error_o, // Parity check failed.
	output logic ordering_enforce_o, // Ordering enforced.
	output logic local_reset_out_n_o, // Local reset out, low.
	output logic wake_request_o, // Wake event request.
	output logic pci_hold_off_o, // PCI accesses retried.
	output logic arbiter_enable_o, // Internal arbiter enabled.
	output logic slv_valid_o, // Slave decode result valid.
	output logic slv_image_o, // Image used.
	output logic [31:0] slv_pci_addr_o, // Translated PCI address.
	output logic slv_bus_error_o, // Slave access gets bus error.
	output logic slv_delayed_write_o, // Write handled as delayed.
	output logic error_irq_o // Error log interrupt request.
);
	import bridge_ctl_pkg::*;

	logic [31:0] misc_two;
	logic [31:0] xlat [2];
	logic log_enable, logged;
	logic [3:0] log_code;
	logic [1:0] log_size;
	logic [31:0] log_addr, log_data;
	logic rom_present, pci_rst_d, boot, rom_busy, rom_start;
	logic [7:0] rom_rdata, rom_addr;
	logic rom_enabled, wr, rd, pci_refused, last_pci;
	logic [15:0] wake_count;
	logic [31:0] mask;
	logic [3:0] raw_parity;

	// ------------------------------------------------------------
	// Request decode
	// ------------------------------------------------------------
	assign pci_refused = reg_req_i && reg_from_pci_i && misc_two[M_HOLD_OFF]; // [R14]
	assign wr = reg_req_i && reg_write_i && !pci_refused;
	assign rd = reg_req_i && !reg_write_i && !pci_refused;
	assign rom_enabled = rom_present || misc_two[M_LATE_ROM]; // [R4]
	assign rom_start = wr && reg_index_i == IDX_ROM_ACCESS && rom_enabled && !rom_busy; // [R1]

	// ------------------------------------------------------------
	// Straps
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rom_present <= 1'b0;
			arbiter_enable_o <= 1'b0;
			pci_rst_d <= 1'b0;
		end else begin
			pci_rst_d <= pci_reset_active_i;
			if (pci_reset_active_i) begin
				rom_present <= rom_clock_line_i || id_strap_pin_i; // [R3]
				arbiter_enable_o <= arbiter_strap_i; // [R15]
			end
		end
	end
	assign boot = pci_rst_d && !pci_reset_active_i && rom_present;

	rom_access_engine #(
		.ACCESS_CYCLES(ACCESS_CYCLES),
		.BOOT_CYCLES(BOOT_CYCLES)
	) u_rom (
		.ref_clk_i(ref_clk_i),
		.reset_n_i(reset_n_i),
		.boot_i(boot),
		.start_i(rom_start),
		.write_i(reg_wdata_i[ROM_WRITE_BIT]),
		.rom_rdata_i(rom_rdata_i),
		.busy_o(rom_busy),
		.rdata_o(rom_rdata)
	);

	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rom_addr <= 8'h00;
		end else if (rom_start) begin
			rom_addr <= reg_wdata_i[ROM_ADDR_LSB +: 8];
		end
	end

	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			misc_two <= MISC_TWO_RESET;
		end else if (pci_reset_active_i) begin
			misc_two[M_HOLD_OFF] <= hold_off_strap_i; // [R14]
		end else if (wr && reg_index_i == IDX_MISC_TWO) begin
			misc_two <= reg_wdata_i & MISC_TWO_WMASK;
		end
	end

	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			xlat[0] <= XLAT_RESET;
			xlat[1] <= XLAT_RESET;
		end else if (wr && reg_index_i == IDX_IMAGE0_XLAT) begin
			xlat[0] <= reg_wdata_i & XLAT_WMASK;
		end else if (wr && reg_index_i == IDX_IMAGE1_XLAT) begin
			xlat[1] <= reg_wdata_i & XLAT_WMASK;
		end
	end

	// ------------------------------------------------------------
	// Error log
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			log_enable <= 1'b0;
			logged <= 1'b0;
			log_code <= 4'h0;
			log_size <= 2'h0;
			log_addr <= 32'h0000_0000;
			log_data <= 32'h0000_0000;
		end else begin
			if (wr && reg_index_i == IDX_ERR_CS) begin
				log_enable <= reg_wdata_i[E_ENABLE];
				if (reg_wdata_i[E_LOGGED] && !reg_wdata_i[E_ENABLE]) begin
					logged <= 1'b0; // [R21]
				end
			end
			if (pw_error_i && !logged) begin
				logged <= 1'b1; // [R20]
				log_code <= pw_code_i;
				log_size <= pw_size_i;
				log_addr <= pw_addr_i;
				log_data <= pw_data_i;
			end
		end
	end

	// ------------------------------------------------------------
	// Register read and termination
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			reg_ack_o <= 1'b0;
			reg_retry_o <= 1'b0;
			reg_rdata_o <= 32'h0000_0000;
		end else begin
			reg_ack_o <= reg_req_i && !pci_refused; // [R2]
			reg_retry_o <= pci_refused; // [R14]
			if (rd) begin
				case (reg_index_i)
					IDX_ROM_ACCESS: begin
						if (!rom_enabled) begin
							reg_rdata_o <= 32'h0000_0000; // [R3]
						end else if (rom_busy) begin
							reg_rdata_o <= 32'h0000_0001 << ROM_BUSY_BIT; // [R1]
						end else begin
							reg_rdata_o <= {16'h0000, rom_addr, rom_rdata};
						end
					end
					IDX_MISC_TWO: begin
						reg_rdata_o <= misc_two | (32'(arbiter_enable_o) << M_ARBITER_EN);
					end
					IDX_IMAGE0_XLAT: reg_rdata_o <= xlat[0];
					IDX_IMAGE1_XLAT: reg_rdata_o <= xlat[1];
					IDX_ERR_CS: begin
						reg_rdata_o <= logged ? {18'h0_0000, log_size, log_code, 6'h00,
							logged, log_enable} : {31'h0000_0000, log_enable}; // [R22]
					end
					IDX_ERR_ADDR: reg_rdata_o <= logged ? log_addr : 32'h0000_0000; // [R22]
					IDX_ERR_DATA: reg_rdata_o <= log_data;
					default: reg_rdata_o <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// Port parking
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			last_pci <= 1'b1;
			port_parked_pci_o <= 1'b1;
		end else begin
			if (reg_req_i) begin
				last_pci <= reg_from_pci_i;
			end
			port_parked_pci_o <= !misc_two[M_PARKING] ||
				(reg_req_i ? reg_from_pci_i : last_pci); // [R9]
		end
	end

	// ------------------------------------------------------------
	// Mode outputs
	// ------------------------------------------------------------
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			raw_parity[i] = ^local_data_i[i*8 +: 8];
		end
	end

	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			abort_bus_error_o <= 1'b0;
			abort_normal_o <= 1'b0;
			full_burst_only_o <= 1'b0;
			single_prefetch_o <= 1'b0;
			image1_prefetch_bytes_o <= 8'h04;
			image1_prefetch_select_o <= 1'b0;
			local_parity_o <= 4'h0;
			parity_error_o <= 1'b0;
			ordering_enforce_o <= 1'b1;
			pci_hold_off_o <= 1'b0;
			wake_request_o <= 1'b0;
			error_irq_o <= 1'b0;
		end else begin
			abort_bus_error_o <= abort_valid_i && (!misc_two[M_ABORT_MAP_DIS] ||
				(abort_is_target_i && misc_two[M_TA_MAP])); // [R5]
			abort_normal_o <= abort_valid_i && misc_two[M_ABORT_MAP_DIS] &&
				!(abort_is_target_i && misc_two[M_TA_MAP]); // [R5]
			full_burst_only_o <= misc_two[M_FULL_BURST]; // [R6]
			single_prefetch_o <= misc_two[M_SINGLE_PF]; // [R7]
			image1_prefetch_bytes_o <= {misc_two[M_PF_COUNT_LSB +: 6], 2'b00}; // [R8]
			image1_prefetch_select_o <= misc_two[M_IMG1_PF_SEL]; // [R8]
			local_parity_o <= raw_parity ^ {4{misc_two[M_PARITY_ODD]}}; // [R10]
			parity_error_o <= (raw_parity ^ {4{misc_two[M_PARITY_ODD]}}) != local_parity_i;
			ordering_enforce_o <= !misc_two[M_ORDER_BYPASS]; // [R11]
			pci_hold_off_o <= misc_two[M_HOLD_OFF]; // [R14]
			wake_request_o <= misc_two[M_IRQ_WAKE] && wake_support_flag_i && in_d3hot_i &&
				!local_interrupt_pin_n_i; // [R13]
			error_irq_o <= logged && log_enable; // [R20]
		end
	end

	// ------------------------------------------------------------
	// Wake reset
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wake_count <= 16'h0000;
			local_reset_out_n_o <= 1'b1;
		end else begin
			if (power_wake_i && misc_two[M_WAKE_RESET]) begin
				wake_count <= 16'(WAKE_CYCLES); // [R12]
			end else if (wake_count != 16'h0000) begin
				wake_count <= wake_count - 16'h0001;
			end
			local_reset_out_n_o <= !((power_wake_i && misc_two[M_WAKE_RESET]) ||
				wake_count > 16'h0001);
		end
	end

	// ------------------------------------------------------------
	// Slave image decode
	// ------------------------------------------------------------
	assign mask = BLOCK_BASE_MASK << xlat[slave_image_select_i][X_BS_LSB +: 4];

	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			slv_valid_o <= 1'b0;
			slv_image_o <= 1'b0;
			slv_pci_addr_o <= 32'h0000_0000;
			slv_bus_error_o <= 1'b0;
			slv_delayed_write_o <= 1'b0;
		end else begin
			slv_valid_o <= !bridge_chip_select_n_i;
			if (!bridge_chip_select_n_i) begin
				slv_image_o <= slave_image_select_i; // [R16]
				slv_pci_addr_o <= xlat[slave_image_select_i][X_REMAP_EN] ?
					((slv_addr_i & ~mask) | (xlat[slave_image_select_i] & mask)) :
					slv_addr_i; // [R19]
				slv_bus_error_o <= slv_burst_i &&
					xlat[slave_image_select_i][X_IO_SPACE]; // [R17]
				slv_delayed_write_o <= slave_image_select_i && slv_posted_i &&
					!slv_burst_i && xlat[1][X_IO_SPACE]; // [R18]
			end
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!reset_n_i);

	a_rom_busy_write: assert property (reg_req_i && reg_write_i && rom_busy &&
		reg_index_i == IDX_ROM_ACCESS |-> !rom_start) // [R1]
		else $error("Rom write accepted while busy.");
	a_write_ack: assert property (reg_req_i && reg_write_i && !pci_refused |=> reg_ack_o) // [R2]
		else $error("Write not terminated normally.");
	a_absent_zero: assert property (rd && reg_index_i == IDX_ROM_ACCESS && !rom_enabled
		|=> reg_rdata_o == 32'h0000_0000) // [R3]
		else $error("Absent rom register read nonzero.");
	a_abort_map: assert property (abort_valid_i && !misc_two[M_ABORT_MAP_DIS]
		|=> abort_bus_error_o && !abort_normal_o) // [R5]
		else $error("Abort not mapped to bus error.");
	a_prefetch_bytes: assert property (##1 image1_prefetch_bytes_o ==
		{$past(misc_two[M_PF_COUNT_LSB +: 6]), 2'b00}) // [R8]
		else $error("Prefetch byte count wrong.");
	a_parking_default: assert property (!misc_two[M_PARKING] |=> port_parked_pci_o) // [R9]
		else $error("Port not on PCI side.");
	a_hold_retry: assert property (reg_req_i && reg_from_pci_i && misc_two[M_HOLD_OFF]
		|=> reg_retry_o && !reg_ack_o) // [R14]
		else $error("PCI access not retried under hold-off.");
	a_wake_reset: assert property (power_wake_i && misc_two[M_WAKE_RESET]
		|=> !local_reset_out_n_o [*2]) // [R12]
		else $error("Wake reset not asserted.");
	a_io_burst: assert property (!bridge_chip_select_n_i && slv_burst_i &&
		xlat[slave_image_select_i][X_IO_SPACE] |=> slv_bus_error_o) // [R17]
		else $error("I/O burst not refused.");
	a_log_set: assert property (pw_error_i && !logged |=> logged) // [R20]
		else $error("Error not logged.");
	a_log_zero: assert property (rd && reg_index_i == IDX_ERR_ADDR && !logged && !pw_error_i
		|=> reg_rdata_o == 32'h0000_0000) // [R22]
		else $error("Log address visible while flag clear.");

	c_rom_access: cover property (rom_start ##1 rom_busy);
	c_hold_off: cover property (reg_retry_o);
	c_log_clear: cover property (logged ##1 !logged);
	c_remap: cover property (slv_valid_o && slv_pci_addr_o != $past(slv_addr_i));
endmodule

// *** src/rom_access_engine.sv ***
// Purpose: Busy sequencer for boot loading and register-driven rom accesses.
// Assumes: Start and boot strobes are one-cycle pulses.
// Notes: Read data is sampled from the rom data input when a read access ends.
`timescale 1ns/1ps
module rom_access_engine #(
	parameter int ACCESS_CYCLES = bridge_ctl_pkg::ROM_ACCESS_CYCLES,
	parameter int BOOT_CYCLES = bridge_ctl_pkg::ROM_BOOT_CYCLES
) (
	input wire logic ref_clk_i, // Clock.
	input wire logic reset_n_i, // Asynchronous reset, active low.
	input wire logic boot_i, // Start of boot load.
	input wire logic start_i, // Register-driven access start.
	input wire logic write_i, // Access is a write.
	input wire logic [7:0] rom_rdata_i, // Data returned by the rom.
	output logic busy_o, // Access or load in progress.
	output logic [7:0] rdata_o // Last read data.
);
	import bridge_ctl_pkg::*;

	logic [15:0] count;
	logic reading;

	// ------------------------------------------------------------
	// Busy counter
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			count <= 16'h0000;
			busy_o <= 1'b0;
			reading <= 1'b0;
		end else if (boot_i) begin
			count <= 16'(BOOT_CYCLES - 1);
			busy_o <= 1'b1;
			reading <= 1'b0;
		end else if (start_i && !busy_o) begin
			count <= 16'(ACCESS_CYCLES - 1);
			busy_o <= 1'b1;
			reading <= !write_i;
		end else if (busy_o) begin
			if (count == 16'h0000) begin
				busy_o <= 1'b0;
				reading <= 1'b0;
			end else begin
				count <= count - 16'h0001;
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rdata_o <= 8'h00;
		end else if (busy_o && reading && count == 16'h0000) begin
			rdata_o <= rom_rdata_i;
		end
	end
endmodule
